// [logic/swc_pkg.sv]
`default_nettype none
package swc_pkg;

  // ==========================================================
  // wait control register layout
  localparam int          SWC_ACK_BIT    = 3;
  localparam int          SWC_NOWAIT_BIT = 2;
  localparam int          SWC_WRQ_HI_BIT = 1;
  localparam int          SWC_WRQ_LO_BIT = 0;
  localparam logic [3:0]  SWC_CTRL_RESET = 4'h0;

  // ==========================================================
  // wait request codes
  localparam logic [1:0]  SWC_WRQ_NONE = 2'h0;
  localparam logic [1:0]  SWC_WRQ_DATA = 2'h1;
  localparam logic [1:0]  SWC_WRQ_ACK  = 2'h2;
  localparam logic [1:0]  SWC_WRQ_ADDR = 2'h3;

  // ==========================================================
  // bit counter figures
  localparam logic [3:0]  SWC_CNT_ZERO = 4'h0;
  localparam logic [3:0]  SWC_CNT_ONE  = 4'h1;
  localparam logic [3:0]  SWC_CNT_DATA = 4'h8;
  localparam logic [3:0]  SWC_CNT_ACK  = 4'h9;

  // ==========================================================
  // internal shift clock half period less one, in link clock cycles
  localparam logic [7:0]  SWC_HALF_PERIOD = 8'h04;

  // software write to the wait control register
  typedef struct packed {
    logic [3:0] data;
    logic       strobe;
  } swc_wr_t;

  // mode selection held by the mode register outside this block
  typedef struct packed {
    logic bus_mode;
    logic clock_direction_flag;
    logic transmit_select_flag;
  } swc_mode_t;

  // shifter clock gate towards the presettable shifter
  typedef struct packed {
    logic shift_rise;
    logic shift_fall;
  } swc_shift_t;

  typedef enum logic [1:0] {
    SWC_GEN_HIGH = 2'b00,
    SWC_GEN_LOW  = 2'b01,
    SWC_GEN_PARK = 2'b11
  } swc_gen_t;

endpackage
`default_nettype wire

// [logic/swc_wait_ctrl.sv]
// Contract
// R1 - register clears on reset and stop
// R2 - wait blocks counter and shifter clocks
// R3 - bus codes 01/10 wait at 8/9
// R4 - code 11 waits first 8 after start
// R5 - serial codes wait high; 11 prohibited
// R6 - slave wait drives bus clock low
// R7 - writing one releases the wait
// R8 - wait mode stays armed after release
// R9 - no-wait flag reads back wait state
// R10 - master wait holds clock low
// R11 - serial internal wait parks clock high
// R12 - serial write clears counter, starts transfer
// R13 - serial internal no wait: clock free-runs
// R14 - external clock edges ignored while waiting
// R15 - writing zero forces immediate wait
// R16 - release resumes clock generation state
// R17 - receive drives ack flag at ack slot
// R18 - software updates ack between ninth bits
// R19 - transmit captures receiver ack into flag
// R20 - software reads ack before next ninth
// R21 - serial mode: ack is plain storage
// R22 - bits: ack, no-wait, request hi/lo
// R23 - counter 0, 1..9 wrap, start clears
// R24 - direction flag: 0 external, 1 internal
// R25 - slave release frees the clock pin
`timescale 1ns/1ns
`default_nettype none

module swc_wait_ctrl
  import swc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       stop_clk,
  input  wire logic       link_clk,
  input  wire logic       link_rst,
  input  wire swc_wr_t    reg_wr,
  input  wire swc_mode_t  mode,
  input  wire logic       start_det,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic [3:0]      reg_rd,
  output logic [3:0]      bit_count,
  output logic            scl_out,
  output logic            scl_oe,
  output logic            sda_ack_out,
  output logic            sda_ack_oe,
  output swc_shift_t      shift_gate
);

  // ==========================================================
  // core domain: register and its bits
  logic [1:0]  wait_request_reg;
  logic        ack_flag_reg;
  logic        wait_reg;        // hardware wait held in core domain
  logic        wr_tgl_reg;      // event toggle to link domain
  logic        rel_tgl_reg;     // release toggle to link domain
  logic        frc_tgl_reg;     // forced wait toggle to link domain
  logic        reset_any;

  // link domain
  logic [3:0]  count_reg;
  logic        addr_done_reg;
  logic        lwait_reg;
  logic        hit_tgl_reg;
  logic        ack_cap_tgl_reg;
  logic        ack_cap_val_reg;
  logic [2:0]  scl_sync_reg;
  logic [2:0]  wr_sync_reg;
  logic [2:0]  rel_sync_reg;
  logic [2:0]  frc_sync_reg;
  logic        wr_seen_reg;
  logic        rel_seen_reg;
  logic        frc_seen_reg;
  logic        scl_seen_reg;
  swc_gen_t    gen_reg;
  swc_gen_t    gen_held_reg;
  logic [7:0]  div_reg;
  logic [1:0]  wrq_l_reg;       // request bits, link copy
  logic        ack_l_reg;       // ack bit, link copy

  // core side sync of link events
  logic [2:0]  hit_sync_reg;
  logic [2:0]  cap_sync_reg;
  logic        hit_seen_reg;
  logic        cap_seen_reg;
  logic        cap_val_meta_reg;
  logic        cap_val_reg;

  assign reset_any = rst | stop_clk;

  // ==========================================================
  // core domain register write
  logic hit_evt;
  logic cap_evt;
  assign hit_evt = (hit_sync_reg[2] == hit_sync_reg[1]) &&
                   (hit_sync_reg[1] != hit_seen_reg);
  assign cap_evt = (cap_sync_reg[2] == cap_sync_reg[1]) &&
                   (cap_sync_reg[1] != cap_seen_reg);

  // request bits steer the wait points
  always_ff @(posedge core_clk) begin
    if (reset_any) begin
      wait_request_reg <= SWC_CTRL_RESET[1:0]; // R1
    end else if (reg_wr.strobe) begin
      wait_request_reg <= reg_wr.data[SWC_WRQ_HI_BIT:SWC_WRQ_LO_BIT]; // R22
    end
  end

  // ack flag: written by software, captured in bus transmit only
  always_ff @(posedge core_clk) begin
    if (reset_any) begin
      ack_flag_reg <= SWC_CTRL_RESET[SWC_ACK_BIT]; // R1
    end else if (cap_evt && mode.bus_mode && mode.transmit_select_flag) begin
      ack_flag_reg <= cap_val_reg; // R19
    end else if (reg_wr.strobe) begin
      ack_flag_reg <= reg_wr.data[SWC_ACK_BIT]; // R17 R21
    end
  end

  // wait state: hardware hit sets, write of one clears, zero forces
  always_ff @(posedge core_clk) begin
    if (reset_any) begin
      wait_reg <= 1'b1; // no-wait flag reads 0 after reset
    end else if (hit_evt) begin
      wait_reg <= 1'b1; // set wins over a release in same cycle
    end else if (reg_wr.strobe) begin
      wait_reg <= ~reg_wr.data[SWC_NOWAIT_BIT]; // R7 R15
    end
  end

  // event toggles towards the link domain; power-on reset only, since
  // clearing them on a stop would fake events at the link side
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_tgl_reg  <= 1'b0;
      rel_tgl_reg <= 1'b0;
      frc_tgl_reg <= 1'b0;
    end else if (reg_wr.strobe && !stop_clk) begin
      wr_tgl_reg <= ~wr_tgl_reg;
      if (reg_wr.data[SWC_NOWAIT_BIT]) begin
        rel_tgl_reg <= ~rel_tgl_reg; // R7
      end else begin
        frc_tgl_reg <= ~frc_tgl_reg; // R15
      end
    end
  end

  // link events into core: three stages, second and third agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hit_sync_reg     <= 3'h0;
      cap_sync_reg     <= 3'h0;
      hit_seen_reg     <= 1'b0;
      cap_seen_reg     <= 1'b0;
      cap_val_meta_reg <= 1'b0;
      cap_val_reg      <= 1'b0;
    end else begin
      hit_sync_reg     <= {hit_sync_reg[1:0], hit_tgl_reg};
      cap_sync_reg     <= {cap_sync_reg[1:0], ack_cap_tgl_reg};
      cap_val_meta_reg <= ack_cap_val_reg; // stable well before toggle
      cap_val_reg      <= cap_val_meta_reg;
      if (hit_evt) begin
        hit_seen_reg <= hit_sync_reg[1];
      end
      if (cap_evt) begin
        cap_seen_reg <= cap_sync_reg[1];
      end
    end
  end

  // readback: no-wait flag shows the held wait
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rd <= SWC_CTRL_RESET;
    end else begin
      reg_rd <= {ack_flag_reg, ~wait_reg, wait_request_reg}; // R9 R22
    end
  end

  // ==========================================================
  // link domain: synchronisers
  logic scl_rise;
  logic scl_fall;
  logic wr_evt;
  logic rel_evt;
  logic frc_evt;
  assign scl_rise = scl_sync_reg[2] == scl_sync_reg[1] &&
                    scl_sync_reg[1] && !scl_seen_reg;
  assign scl_fall = scl_sync_reg[2] == scl_sync_reg[1] &&
                    !scl_sync_reg[1] && scl_seen_reg;
  assign wr_evt  = (wr_sync_reg[2] == wr_sync_reg[1]) &&
                   (wr_sync_reg[1] != wr_seen_reg);
  assign rel_evt = (rel_sync_reg[2] == rel_sync_reg[1]) &&
                   (rel_sync_reg[1] != rel_seen_reg);
  assign frc_evt = (frc_sync_reg[2] == frc_sync_reg[1]) &&
                   (frc_sync_reg[1] != frc_seen_reg);

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_sync_reg <= 3'h7;
      wr_sync_reg  <= 3'h0;
      rel_sync_reg <= 3'h0;
      frc_sync_reg <= 3'h0;
      scl_seen_reg <= 1'b1;
      wr_seen_reg  <= 1'b0;
      rel_seen_reg <= 1'b0;
      frc_seen_reg <= 1'b0;
    end else begin
      scl_sync_reg  <= {scl_sync_reg[1:0], scl_in};
      wr_sync_reg   <= {wr_sync_reg[1:0], wr_tgl_reg};
      rel_sync_reg  <= {rel_sync_reg[1:0], rel_tgl_reg};
      frc_sync_reg  <= {frc_sync_reg[1:0], frc_tgl_reg};
      if (scl_rise || scl_fall) begin
        scl_seen_reg <= scl_sync_reg[1];
      end
      if (wr_evt) begin
        wr_seen_reg <= wr_sync_reg[1];
      end
      if (rel_evt) begin
        rel_seen_reg <= rel_sync_reg[1];
      end
      if (frc_evt) begin
        frc_seen_reg <= frc_sync_reg[1];
      end
    end
  end

  // ==========================================================
  // wait point match on copies taken at the write event
  logic [1:0] wrq_l;
  logic       cnt_next_hit;
  logic [3:0] count_next;
  logic [3:0] match_cnt;
  logic       count_edge;

  // register bits settle before their toggle lands, so one capture
  // at the write event crosses them without a torn word
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      wrq_l_reg <= SWC_WRQ_NONE;
      ack_l_reg <= 1'b0;
    end else if (wr_evt) begin
      wrq_l_reg <= wait_request_reg;
      ack_l_reg <= ack_flag_reg;
    end
  end

  assign wrq_l = wrq_l_reg;
  // bus mode matches the count held at the fall, serial the count
  // that the rise is about to reach
  assign match_cnt = mode.bus_mode ? count_reg : count_next;
  assign count_edge = !lwait_reg && scl_rise; // R2 R14
  assign count_next = (count_reg == SWC_CNT_ACK) ? SWC_CNT_ONE :
                      count_reg + SWC_CNT_ONE; // R23

  always_comb begin
    cnt_next_hit = 1'b0;
    case (wrq_l)
      SWC_WRQ_DATA: cnt_next_hit = match_cnt == SWC_CNT_DATA; // R3 R5
      SWC_WRQ_ACK:  cnt_next_hit = match_cnt == SWC_CNT_ACK;  // R3 R5
      SWC_WRQ_ADDR: cnt_next_hit = mode.bus_mode && !addr_done_reg &&
                                   match_cnt == SWC_CNT_DATA; // R4 R5
      default:      cnt_next_hit = 1'b0;
    endcase
  end

  // bus mode waits at the falling edge, serial mode with clock high
  logic wait_hit;
  assign wait_hit = !lwait_reg && cnt_next_hit &&
                    (mode.bus_mode ? scl_fall : scl_rise); // R3 R5 R8

  // bit counter
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      count_reg     <= SWC_CNT_ZERO;
      addr_done_reg <= 1'b0;
    end else if (mode.bus_mode && start_det) begin
      count_reg     <= SWC_CNT_ZERO; // R23
      addr_done_reg <= 1'b0;
    end else if (!mode.bus_mode && wr_evt) begin
      count_reg <= SWC_CNT_ZERO; // R12
    end else if (count_edge) begin
      count_reg <= count_next;
    end else if (wait_hit && wrq_l == SWC_WRQ_ADDR) begin
      addr_done_reg <= 1'b1; // R4
    end
  end

  // link side wait: hit or force sets, release clears
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lwait_reg   <= 1'b1;
      hit_tgl_reg <= 1'b0;
    end else if (wait_hit) begin
      lwait_reg   <= 1'b1; // R8
      hit_tgl_reg <= ~hit_tgl_reg;
    end else if (frc_evt) begin
      lwait_reg <= 1'b1; // R15
    end else if (rel_evt) begin
      lwait_reg <= 1'b0; // R7
    end
  end

  // ack capture on the ninth rising edge in transmit
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ack_cap_tgl_reg <= 1'b0;
      ack_cap_val_reg <= 1'b0;
    end else if (count_edge && count_next == SWC_CNT_ACK &&
                 mode.bus_mode && mode.transmit_select_flag) begin
      ack_cap_val_reg <= sda_in; // R19
      ack_cap_tgl_reg <= ~ack_cap_tgl_reg;
    end
  end

  // ==========================================================
  // internal shift clock generator; held state resumes on release
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      gen_reg      <= SWC_GEN_HIGH;
      gen_held_reg <= SWC_GEN_HIGH;
      div_reg      <= 8'h00;
    end else if (!mode.clock_direction_flag) begin
      gen_reg <= SWC_GEN_HIGH; // R24
      div_reg <= 8'h00;
    end else begin
      case (gen_reg)
        SWC_GEN_PARK: begin
          if (rel_evt) begin
            gen_reg <= gen_held_reg; // R16
          end
        end
        SWC_GEN_HIGH, SWC_GEN_LOW: begin
          // parking on the hit itself avoids a stray clock pulse
          if (lwait_reg || frc_evt || wait_hit) begin
            gen_held_reg <= gen_reg;
            gen_reg      <= SWC_GEN_PARK; // R10 R11 R15
          end else if (div_reg == SWC_HALF_PERIOD) begin
            div_reg <= 8'h00;
            gen_reg <= (gen_reg == SWC_GEN_HIGH) ? SWC_GEN_LOW
                                                 : SWC_GEN_HIGH; // R13
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        default: gen_reg <= SWC_GEN_HIGH;
      endcase
    end
  end

  // ==========================================================
  // pin drive
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_out     <= 1'b1;
      scl_oe      <= 1'b0;
      sda_ack_out <= 1'b1;
      sda_ack_oe  <= 1'b0;
      bit_count   <= SWC_CNT_ZERO;
      shift_gate  <= '0;
    end else begin
      bit_count <= count_reg;
      // shifter sees only unblocked edges; bus mode only counts 1..8
      shift_gate.shift_rise <= count_edge &&
        (!mode.bus_mode || count_next != SWC_CNT_ACK); // R2
      shift_gate.shift_fall <= !lwait_reg && scl_fall; // R2
      if (mode.clock_direction_flag) begin
        scl_oe <= 1'b1;
        if (gen_reg == SWC_GEN_PARK) begin
          scl_out <= !mode.bus_mode; // R10 R11
        end else begin
          scl_out <= gen_reg == SWC_GEN_HIGH;
        end
      end else begin
        // bus slave with a request code set stretches low while waiting, frees pin on release
        scl_oe  <= mode.bus_mode && lwait_reg &&
                   wrq_l != SWC_WRQ_NONE; // R6 R25
        scl_out <= 1'b0; // R6
      end
      // ack slot: eighth fall to ninth fall in bus receive, so the
      // level stands before the ninth rise samples it
      if (!mode.bus_mode || mode.transmit_select_flag || start_det) begin
        sda_ack_oe <= 1'b0;
      end else if (!lwait_reg && scl_fall) begin
        sda_ack_oe <= count_reg == SWC_CNT_DATA; // R17
      end
      sda_ack_out <= ack_l_reg; // taken at the write event
    end
  end

endmodule

`default_nettype wire

// [verif/swc_far_end.sv]
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// far device: drives clock and data open drain
module swc_far_end #(
  parameter int HALF_NS = 60
) (
  input  wire logic scl_wire,
  input  wire logic sda_wire,
  output var logic  scl_low,
  output var logic  sda_low,
  output var logic  last_bit
);
  // both lines released; clock stands still between frames
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    last_bit = 1'b0;
  end
  // start: data falls while clock high
  task automatic open_frame();
    sda_low = 1'b1;
    #(HALF_NS);
    scl_low = 1'b1;
    #(HALF_NS);
  endtask
  // msb first; a stretched clock is waited out, not overridden
  task automatic send(input int n, input logic [8:0] v);
    for (int i = 0; i < n; i++) begin
      sda_low = !v[8 - i];
      #(HALF_NS);
      scl_low = 1'b0;
      wait (scl_wire === 1'b1);
      last_bit = sda_wire;
      #(HALF_NS);
      scl_low = 1'b1;
    end
  endtask
  // stop: clock released, then data
  task automatic close_frame();
    sda_low = 1'b1;
    #(HALF_NS);
    scl_low = 1'b0;
    #(HALF_NS);
    sda_low = 1'b0;
  endtask
endmodule
`default_nettype wire

// [verif/swc_sva.sv]
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// wait control checker
module swc_sva
  import swc_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       stop_clk,
  input wire logic       link_clk,
  input wire logic       link_rst,
  input wire swc_wr_t    reg_wr,
  input wire swc_mode_t  mode,
  input wire logic [3:0] reg_rd,
  input wire logic [3:0] bit_count,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_ack_oe,
  input wire swc_shift_t shift_gate
);
  // only a bus slave stretches the clock line low
  logic slv;
  assign slv = mode.bus_mode && !mode.clock_direction_flag;

  chk_reset_clear: assert property (
    @(posedge core_clk) rst [*2] |=> reg_rd == SWC_CTRL_RESET)
    else $error("reset left bits set");
  chk_stop_clear: assert property (
    @(posedge core_clk) disable iff (rst) stop_clk [*2] |=> reg_rd == 4'h0)
    else $error("stop left bits set");
  chk_write_back: assert property (
    @(posedge core_clk) disable iff (rst || stop_clk)
    reg_wr.strobe |-> ##2 reg_rd[2:0] == $past(reg_wr.data[2:0], 2))
    else $error("readback differs from write");
  chk_release_pin: assert property (
    @(posedge core_clk) disable iff (rst)
    reg_wr.strobe && reg_wr.data[SWC_NOWAIT_BIT] && slv |-> ##[1:4] !scl_oe)
    else $error("stretch not released");
  chk_stretch_count: assert property (
    @(posedge link_clk) disable iff (link_rst) $rose(scl_oe) && slv |->
    bit_count == ((reg_rd[1:0] == SWC_WRQ_ACK) ? SWC_CNT_ACK : SWC_CNT_DATA))
    else $error("stretch at wrong count");
  chk_slave_low: assert property (
    @(posedge link_clk) disable iff (link_rst) scl_oe && slv |-> !scl_out)
    else $error("slave drives clock high");
  chk_count_step: assert property (
    @(posedge link_clk) disable iff (link_rst) $changed(bit_count) |->
    bit_count <= SWC_CNT_ONE ||
    (bit_count == $past(bit_count) + 4'h1 && bit_count <= SWC_CNT_ACK))
    else $error("counter out of sequence");
  chk_stall_count: assert property (
    @(posedge link_clk) disable iff (link_rst) scl_oe && $past(scl_oe) && slv
    |-> $stable(bit_count) && !shift_gate.shift_rise)
    else $error("counter moved in wait");
  chk_ack_slot: assert property (
    @(posedge link_clk) disable iff (link_rst)
    sda_ack_oe |-> mode.bus_mode && bit_count >= SWC_CNT_DATA)
    else $error("ack driven outside its slot");

  cover property (@(posedge link_clk) $rose(scl_oe) && bit_count == 4'h9);
  cover property (@(posedge core_clk) $fell(reg_rd[SWC_NOWAIT_BIT]));
  cover property (@(posedge link_clk) sda_ack_oe && slv);
endmodule

bind swc_wait_ctrl swc_sva u_sva (
  .core_clk(core_clk),
  .rst(rst),
  .stop_clk(stop_clk),
  .link_clk(link_clk),
  .link_rst(link_rst),
  .reg_wr(reg_wr),
  .mode(mode),
  .reg_rd(reg_rd),
  .bit_count(bit_count),
  .scl_out(scl_out),
  .scl_oe(scl_oe),
  .sda_ack_oe(sda_ack_oe),
  .shift_gate(shift_gate)
);
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// bench top
module tb_top
  import swc_pkg::*;
;
  logic       core_clk, link_clk, rst, link_rst, stop_clk, start_det;
  logic       scl_in, sda_in, scl_out, scl_oe, sda_ack_out, sda_ack_oe;
  logic       scl_low, sda_low, last_bit;
  logic [3:0] reg_rd, bit_count;
  swc_wr_t    reg_wr;
  swc_mode_t  mode;
  swc_shift_t shift_gate;
  int         err_total, check_count, cyc, rises, r0, falls, f0;

  swc_wait_ctrl u_dut (
    .core_clk(core_clk), .rst(rst), .stop_clk(stop_clk),
    .link_clk(link_clk), .link_rst(link_rst), .reg_wr(reg_wr),
    .mode(mode), .start_det(start_det), .scl_in(scl_in),
    .sda_in(sda_in), .reg_rd(reg_rd), .bit_count(bit_count),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_ack_out(sda_ack_out),
    .sda_ack_oe(sda_ack_oe), .shift_gate(shift_gate));
  swc_far_end u_far (
    .scl_wire(scl_in), .sda_wire(sda_in), .scl_low(scl_low),
    .sda_low(sda_low), .last_bit(last_bit));

  // pull-ups: a line is low while any party pulls it low
  assign scl_in = !((scl_oe && !scl_out) || scl_low);
  assign sda_in = !((sda_ack_oe && !sda_ack_out) || sda_low);

  always #50 core_clk = ~core_clk;
  // link clock offset by 2 ns; its edges still meet the core's every 150 ns, from 50 ns on
  initial begin
    link_clk = 1'b0;
    #2;
    forever #6 link_clk = ~link_clk;
  end
  // shifter pulses, used to see whether a wait really stalls
  always @(posedge link_clk) begin
    if (shift_gate.shift_rise === 1'b1)
      rises <= rises + 1;
    if (shift_gate.shift_fall === 1'b1)
      falls <= falls + 1;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // one-cycle write strobe, then a gap of one cycle
  task automatic wr(input logic [3:0] d);
    @(negedge core_clk);
    reg_wr.data = d;
    reg_wr.strobe = 1'b1;
    @(negedge core_clk);
    reg_wr.strobe = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic frame(input logic [2:0] m);
    @(negedge core_clk);
    mode = swc_mode_t'(m);
    start_det = 1'b1;
    @(negedge core_clk);
    start_det = 1'b0;
    u_far.open_frame();
  endtask
  // bounded poll for the no-wait flag to drop
  task automatic until_wait();
    for (int i = 0; i < 80; i++)
      if (reg_rd[SWC_NOWAIT_BIT] !== 1'b0)
        @(negedge core_clk);
    idle(4);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic t_regs();
    chk(reg_rd, SWC_CTRL_RESET);
    chk({2'h0, scl_oe, sda_ack_oe}, 4'h0);
    wr(4'hd);
    chk(reg_rd, 4'hd);
    wr(4'h8);
    chk(reg_rd, 4'h8);
    stop_clk = 1'b1;
    idle(2);
    stop_clk = 1'b0;
    idle(1);
    chk(reg_rd, 4'h0);
  endtask
  task automatic t_slave();
    wr(4'h5);
    frame(3'h4);
    u_far.send(8, 9'h14b);
    idle(8);
    chk(bit_count, SWC_CNT_DATA);
    chk({2'h0, scl_oe, scl_out}, 4'h2);
    chk(reg_rd, 4'h1);
    wr(4'h5);
    u_far.send(9, 9'h1c3);
    idle(8);
    chk(reg_rd, 4'h1);
    chk(bit_count, SWC_CNT_DATA);
    wr(4'h4);
    u_far.send(1, 9'h1ff);
    idle(4);
    chk(bit_count, SWC_CNT_ACK);
  endtask
  // ack flag set 0, 1, then 1 while waiting at the ninth bit; acks seen on the line 0, 0, then 1
  task automatic t_ack();
    wr(4'h6);
    frame(3'h4);
    for (int i = 0; i < 3; i++) begin
      u_far.send(9, 9'h155);
      idle(8);
      chk(bit_count, SWC_CNT_ACK);
      chk({3'h0, last_bit}, {3'h0, i == 2});
      wr(i == 0 ? 4'h6 : 4'he);
    end
  endtask
  task automatic t_tx();
    frame(3'h5);
    u_far.send(9, 9'h154);
    idle(8);
    chk(reg_rd, 4'h2);
    wr(4'hc);
    chk(reg_rd, 4'hc);
  endtask
  task automatic t_addr();
    wr(4'h7);
    frame(3'h4);
    u_far.send(8, 9'h1a0);
    idle(8);
    chk(reg_rd, 4'h3);
    wr(4'h7);
    u_far.send(9, 9'h1ff);
    idle(8);
    chk(reg_rd, 4'h7);
    chk(bit_count, SWC_CNT_DATA);
    u_far.close_frame();
  endtask
  task automatic t_ext();
    mode = swc_mode_t'(3'h0);
    wr(4'hd);
    chk(bit_count, SWC_CNT_ZERO);
    u_far.open_frame();
    u_far.send(8, 9'h000);
    idle(8);
    r0 = rises;
    f0 = falls;
    u_far.send(3, 9'h000);
    u_far.close_frame();
    idle(8);
    chk(bit_count, SWC_CNT_DATA);
    chk({3'h0, rises == r0}, 4'h1);
    chk({3'h0, falls == f0}, 4'h1);
    chk(reg_rd, 4'h9);
    wr(4'hd);
    idle(2);
    chk(bit_count, SWC_CNT_ZERO);
  endtask
  task automatic t_int();
    mode = swc_mode_t'(3'h2);
    wr(4'h5);
    until_wait();
    chk(bit_count, SWC_CNT_DATA);
    chk({2'h0, scl_oe, scl_out}, 4'h3);
    wr(4'h4);
    r0 = rises;
    idle(20);
    chk({3'h0, rises - r0 > 15}, 4'h1);
    wr(4'h0);
    idle(2);
    r0 = rises;
    idle(10);
    chk({3'h0, rises == r0}, 4'h1);
    chk(bit_count, SWC_CNT_ZERO);
    wr(4'h4);
    idle(10);
    chk({3'h0, rises != r0}, 4'h1);
  endtask
  task automatic t_master();
    mode = swc_mode_t'(3'h6);
    start_det = 1'b1;
    idle(1);
    start_det = 1'b0;
    wr(4'h5);
    until_wait();
    chk(bit_count, SWC_CNT_DATA);
    chk({3'h0, scl_out}, 4'h0);
  endtask

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    link_rst = 1'b1;
    stop_clk = 1'b0;
    start_det = 1'b0;
    reg_wr = '0;
    mode = swc_mode_t'(3'h4);
    {err_total, check_count, cyc, rises, r0, falls, f0} = '0;
    idle(8);
    rst = 1'b0;
    link_rst = 1'b0;
    t_regs();
    $display("end regs");
    t_slave();
    $display("end slave");
    t_ack();
    $display("end ack");
    t_tx();
    $display("end tx");
    t_addr();
    $display("end addr");
    t_ext();
    $display("end ext");
    t_int();
    $display("end int");
    t_master();
    $display("end master");
    final_report();
  end
endmodule
`default_nettype wire
